// ===== pwm_square_consts.svh
// Register map, reset values and timing counts of the pulse-width and square-wave outputs
// Contract
// - Pulse-width output selectable on sixteen pins
// - Pulse-width frequency programmable, up to 1 MHz
// - Duty programmable from 0% to 100%
// - Duty steps equal period in microseconds
// - Waveform runs in hardware without software
// - Square wave selectable on sixteen pins
// - Common square frequency, per-pin duty
// - Square wave 0 Hz to 4 MHz, 50% default
`ifndef PWM_SQUARE_CONSTS_SVH
`define PWM_SQUARE_CONSTS_SVH

// Byte addresses on the register bus
`define ADDR_CTRL 8'h00
`define ADDR_PWM_PERIOD 8'h04
`define ADDR_PWM_DUTY 8'h08
`define ADDR_SQ_PERIOD 8'h0C
`define ADDR_PWM_SEL 8'h10
`define ADDR_SQ_SEL 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_SQ_DUTY_BASE 8'h40
`define ADDR_SQ_DUTY_MASK 8'hC0

// Field positions
`define CTRL_PWM_EN 0
`define CTRL_SQ_EN 1
`define STATUS_LEVEL 16

// Reset values
`define PWM_PERIOD_RST 16'h03E8
`define PWM_DUTY_RST 16'h0000
`define SQ_PERIOD_RST 16'h0028
`define SQ_DUTY_RST 9'h080
`define SQ_DUTY_FULL 9'h100

// Timing
`define MCLK_PERIOD_NS 25
`define TICK_NS 1000
`define TICK_CYC (`TICK_NS / `MCLK_PERIOD_NS)
`define SQ_MIN_PERIOD_NS 250
`define SQ_MIN_CYC ((`SQ_MIN_PERIOD_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define PWM_MIN_PERIOD 16'h0001

`endif

// ===== pwm_square_pkg.sv
// Types shared by the pulse-width and square-wave output logic
`default_nettype none
package pwm_square_pkg;
  typedef struct packed {
    logic [15:0] period;
    logic [15:0] duty;
  } pwmCfg_t;

  typedef struct packed {
    logic sqEn;
    logic pwmEn;
  } ctrl_t;
endpackage : pwm_square_pkg
`default_nettype wire

// ===== sq_channel.sv
// One square-wave pin: compares the shared phase against its own duty fraction
`timescale 1ns/1ps
`default_nettype none
`include "pwm_square_consts.svh"
module sq_channel #(
  parameter int SQ_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Shared phase and own duty
  input wire logic enable,
  input wire logic [SQ_W-1:0] phase,
  input wire logic [SQ_W-1:0] period,
  input wire logic [8:0] duty,
  // Level
  output logic level_ff
);
  logic nxt_level;

  // Duty is in 1/256 of the period; 256 means constantly high
  always_comb begin
    nxt_level = enable && (period != '0) &&
                ({1'b0, phase, 8'h00} < ((SQ_W + 9)'(period) * (SQ_W + 9)'(duty)));
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      level_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_sq_zero_low: assert property (duty == 9'h000 |=> !level_ff)
    else $error("square output high with zero duty");
  chk_sq_full_high: assert property (enable && period != '0 && phase < period && duty == `SQ_DUTY_FULL
                                     |=> level_ff)
    else $error("square output low with full duty");
endmodule : sq_channel
`default_nettype wire

// ===== pwm_square_top.sv
// Pulse-width and programmable square-wave pin outputs with a classic Wishbone register slave
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_square_consts.svh"
module pwm_square_top
  import pwm_square_pkg::*;
#(
  parameter int PINS = 16,
  parameter int SQ_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // General-purpose pin side
  input wire logic [PINS-1:0] gpOut,
  input wire logic [PINS-1:0] gpOe,
  output logic [PINS-1:0] pinOut,
  output logic [PINS-1:0] pinOeN
);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wr[8*b +: 8];
      end
    end
    return res;
  endfunction : byteMerge

  function automatic logic isSqDuty(input logic [7:0] a);
    return (a & `ADDR_SQ_DUTY_MASK) == `ADDR_SQ_DUTY_BASE;
  endfunction : isSqDuty

  ////////////////////////////////////////////////////////////////////////////////
  // Register file
  ctrl_t ctrl_ff, nxt_ctrl;
  pwmCfg_t cfg_ff, nxt_cfg;
  logic [SQ_W-1:0] sqPer_ff, nxt_sqPer;
  logic [PINS-1:0] pwmSel_ff, nxt_pwmSel, sqSel_ff, nxt_sqSel;
  logic [8:0] sqDuty_ff [PINS], nxt_sqDuty [PINS];
  logic [31:0] rdData_ff, nxt_rdData;
  logic ack_ff, nxt_ack;
  logic wrEn;
  logic [31:0] merged;
  logic [31:0] rdMux;
  logic [15:0] pwmCnt_ff;
  logic pwmLevel_ff;

  always_comb begin
    nxt_ack = cyc_i && stb_i && !ack_ff;
    wrEn = nxt_ack && we_i;
    nxt_ctrl = ctrl_ff;
    nxt_cfg = cfg_ff;
    nxt_sqPer = sqPer_ff;
    nxt_pwmSel = pwmSel_ff;
    nxt_sqSel = sqSel_ff;
    nxt_sqDuty = sqDuty_ff;
    rdMux = 32'h0000_0000;
    merged = 32'h0000_0000;
    unique case (adr_i)
      `ADDR_CTRL: rdMux = 32'(ctrl_ff);
      `ADDR_PWM_PERIOD: rdMux = {16'h0000, cfg_ff.period};
      `ADDR_PWM_DUTY: rdMux = {16'h0000, cfg_ff.duty};
      `ADDR_SQ_PERIOD: rdMux = 32'(sqPer_ff);
      `ADDR_PWM_SEL: rdMux = 32'(pwmSel_ff);
      `ADDR_SQ_SEL: rdMux = 32'(sqSel_ff);
      `ADDR_STATUS: rdMux = {15'h0000, pwmLevel_ff, pwmCnt_ff};
      default: rdMux = isSqDuty(adr_i) ? 32'(sqDuty_ff[adr_i[5:2]]) : 32'h0000_0000;
    endcase
    merged = byteMerge(rdMux, dat_i, sel_i);
    if (wrEn) begin
      unique case (adr_i)
        `ADDR_CTRL: nxt_ctrl = ctrl_t'(merged[1:0]);
        // Period of zero ticks would let the counter run to 65535 before it wraps; floor at one tick (1 MHz)
        `ADDR_PWM_PERIOD: nxt_cfg.period = (merged[15:0] < `PWM_MIN_PERIOD) ? `PWM_MIN_PERIOD : merged[15:0];
        `ADDR_PWM_DUTY: nxt_cfg.duty = merged[15:0];
        // Zero means 0 Hz; anything faster than 4 MHz is raised to the floor
        `ADDR_SQ_PERIOD: nxt_sqPer = (merged[SQ_W-1:0] != '0 && merged[SQ_W-1:0] < SQ_W'(`SQ_MIN_CYC)) ?
                                     SQ_W'(`SQ_MIN_CYC) : merged[SQ_W-1:0];
        `ADDR_PWM_SEL: nxt_pwmSel = merged[PINS-1:0];
        `ADDR_SQ_SEL: nxt_sqSel = merged[PINS-1:0];
        default: begin
          if (isSqDuty(adr_i)) begin
            nxt_sqDuty[adr_i[5:2]] = (merged[8:0] > `SQ_DUTY_FULL) ? `SQ_DUTY_FULL : merged[8:0];
          end
        end
      endcase
    end
    nxt_rdData = (nxt_ack && !we_i) ? rdMux : 32'h0000_0000;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_ff <= '0;
      cfg_ff <= '{period: `PWM_PERIOD_RST, duty: `PWM_DUTY_RST};
      sqPer_ff <= SQ_W'(`SQ_PERIOD_RST);
      pwmSel_ff <= '0;
      sqSel_ff <= '0;
      for (int i = 0; i < PINS; i++) begin
        sqDuty_ff[i] <= `SQ_DUTY_RST;
      end
      rdData_ff <= 32'h0000_0000;
      ack_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      cfg_ff <= nxt_cfg;
      sqPer_ff <= nxt_sqPer;
      pwmSel_ff <= nxt_pwmSel;
      sqSel_ff <= nxt_sqSel;
      sqDuty_ff <= nxt_sqDuty;
      rdData_ff <= nxt_rdData;
      ack_ff <= nxt_ack;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdData_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse-width generator on the microsecond tick
  logic [5:0] pre_ff, nxt_pre;
  logic tick;
  logic [15:0] nxt_pwmCnt;
  pwmCfg_t act_ff, nxt_act;
  logic nxt_pwmLevel;

  always_comb begin
    tick = (pre_ff == 6'(`TICK_CYC - 1));
    nxt_pre = tick ? 6'h00 : 6'(pre_ff + 6'h01);
    nxt_pwmCnt = pwmCnt_ff;
    nxt_act = act_ff;
    if (!ctrl_ff.pwmEn) begin
      nxt_pwmCnt = 16'h0000;
      nxt_act = cfg_ff;
    end else if (tick) begin
      // New settings take effect only at a period boundary, so no runt pulses
      if (pwmCnt_ff >= 16'(act_ff.period - 16'h0001)) begin
        nxt_pwmCnt = 16'h0000;
        nxt_act = cfg_ff;
      end else begin
        nxt_pwmCnt = 16'(pwmCnt_ff + 16'h0001);
      end
    end
    nxt_pwmLevel = ctrl_ff.pwmEn && (nxt_pwmCnt < nxt_act.duty);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pre_ff <= 6'h00;
      pwmCnt_ff <= 16'h0000;
      act_ff <= '{period: `PWM_PERIOD_RST, duty: `PWM_DUTY_RST};
      pwmLevel_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      pwmCnt_ff <= nxt_pwmCnt;
      act_ff <= nxt_act;
      pwmLevel_ff <= nxt_pwmLevel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Square-wave phase shared by all pins
  logic [SQ_W-1:0] sqCnt_ff, nxt_sqCnt;
  logic [PINS-1:0] sqLevel;

  always_comb begin
    if (!ctrl_ff.sqEn || sqPer_ff == '0 || sqCnt_ff >= SQ_W'(sqPer_ff - SQ_W'(1))) begin
      nxt_sqCnt = '0;
    end else begin
      nxt_sqCnt = SQ_W'(sqCnt_ff + SQ_W'(1));
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sqCnt_ff <= '0;
    end else begin
      sqCnt_ff <= nxt_sqCnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-pin alternate function selection
  logic [PINS-1:0] pinOut_ff, nxt_pinOut;

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    sq_channel #(.SQ_W(SQ_W)) u_sq (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .enable(ctrl_ff.sqEn),
      .phase(sqCnt_ff),
      .period(sqPer_ff),
      .duty(sqDuty_ff[i]),
      .level_ff(sqLevel[i])
    );
    always_comb begin
      nxt_pinOut[i] = pwmSel_ff[i] ? pwmLevel_ff : (sqSel_ff[i] ? sqLevel[i] : gpOut[i]);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pinOut_ff <= '0;
    end else begin
      pinOut_ff <= nxt_pinOut;
    end
  end

  assign pinOut = pinOut_ff;
  assign pinOeN = ~(pwmSel_ff | sqSel_ff | gpOe);

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_wb_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");
  chk_wb_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  chk_tick_spacing: assert property (tick |-> ##40 tick)
    else $error("microsecond tick not every 40 clocks");
  chk_tick_quiet: assert property (tick |=> !tick [*8])
    else $error("microsecond tick repeated early");
  chk_pwm_zero_low: assert property (pwmLevel_ff |-> act_ff.duty != 16'h0000)
    else $error("pulse output high with zero duty");
  chk_pwm_full_high: assert property ($past(ctrl_ff.pwmEn) && act_ff.duty >= act_ff.period |-> pwmLevel_ff)
    else $error("pulse output low at full duty");
  chk_pwm_count_range: assert property (pwmCnt_ff < act_ff.period)
    else $error("pulse counter beyond period");
  chk_pin_route: assert property ($past(pwmSel_ff[0]) |-> pinOut[0] == $past(pwmLevel_ff))
    else $error("pin 0 does not follow pulse output");
  chk_sq_period_floor: assert property (sqPer_ff == '0 || sqPer_ff >= SQ_W'(`SQ_MIN_CYC))
    else $error("square period faster than 4 MHz");
  chk_sq_phase_wrap: assert property ($stable(sqPer_ff) && sqPer_ff != '0 && $past(sqCnt_ff) < sqPer_ff
                                      |-> sqCnt_ff < sqPer_ff)
    else $error("square phase beyond period");
endmodule : pwm_square_top
`default_nettype wire

// ===== pin_load.sv
// External load on the output pins: pull-down on each pin, counts high cycles
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  // Clock
  input wire logic mclk,
  // Measuring window
  input wire logic run,
  input wire logic clear,
  // Pins
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOeN,
  output logic [15:0][15:0] highCnt
);
  logic [15:0] pinLevel;
  // Undriven pin falls to the pull-down
  assign pinLevel = pinOut & ~pinOeN;
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 16; i++) begin
      if (clear) begin
        highCnt[i] <= 16'h0000;
      end else if (run) begin
        highCnt[i] <= highCnt[i] + {15'h0000, pinLevel[i]};
      end
    end
  end
endmodule : pin_load
`default_nettype wire

// ===== pwm_and_square_wave_outputs_tb.sv
// Self-checking bench for the pulse-width and square-wave pin outputs
`timescale 1ns/1ps
`default_nettype none
`include "pwm_square_consts.svh"
module pwm_and_square_wave_outputs_tb;
  logic mclk = 1'b0;
  logic sysRst, cyc, stb, we, ack, run, clear;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] datIn, datOut, rdq;
  logic [15:0] gpOut, gpOe, pinOut, pinOeN, pwmSel, sqSel, pwmPer, pwmDuty, sqPer;
  logic [15:0][15:0] highCnt;
  logic [8:0] sqDuty [16];
  int miscompares = 0;
  int total_checks = 0;

  always #12.5 mclk = ~mclk;

  pwm_square_top #(.PINS(16), .SQ_W(16)) pwm_square_top_inst (.mclk(mclk), .sys_rst(sysRst), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .sel_i(sel), .adr_i(adr), .dat_i(datIn), .dat_o(datOut), .ack_o(ack),
    .gpOut(gpOut), .gpOe(gpOe), .pinOut(pinOut), .pinOeN(pinOeN));
  pin_load pin_load_inst (.mclk(mclk), .run(run), .clear(clear), .pinOut(pinOut), .pinOeN(pinOeN),
    .highCnt(highCnt));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic cmpVal(input string what, input logic [31:0] expV, input logic [31:0] gotV);
    total_checks++;
    if (gotV !== expV) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, expV, gotV);
    end
  endtask : cmpVal

  // One classic cycle, entered just after a rising edge
  task automatic wbCycle(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    datIn <= d;
    sel <= s;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = datOut;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask : wbCycle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbCycle(1'b1, a, d, 4'hF, q);
  endtask : wr

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wbCycle(1'b0, a, '0, 4'hF, q);
    cmpVal(what, e, q);
  endtask : rdChk

  function automatic int pinExp(int i, int w);
    if (pwmSel[i]) return ((pwmDuty > pwmPer) ? int'(pwmPer) : int'(pwmDuty)) * w / pwmPer;
    if (sqSel[i]) return (sqPer == 0) ? 0 : ((sqPer * sqDuty[i] + 255) / 256) * w / sqPer;
    return (gpOe[i] & gpOut[i]) ? w : 0;
  endfunction : pinExp

  task automatic measure(input int cycles);
    clear <= 1'b1;
    @(posedge mclk);
    clear <= 1'b0;
    run <= 1'b1;
    repeat (cycles) @(posedge mclk);
    run <= 1'b0;
    @(posedge mclk);
  endtask : measure

  task automatic runCase(input int k);
    int w;
    pwmPer = 16'(2 + $urandom % 9);
    pwmDuty = (k == 0) ? 16'h0000 : (k == 1) ? pwmPer : 16'($urandom % (pwmPer + 2));
    if (k == 2) begin
      pwmPer = 16'h0002;
      pwmDuty = 16'h0001;
    end
    sqPer = (k == 3) ? 16'h0000 : 16'(10 * (1 + $urandom % 4));
    pwmSel = 16'($urandom);
    sqSel = 16'($urandom);
    gpOe <= 16'($urandom);
    gpOut <= 16'($urandom);
    wr(`ADDR_CTRL, '0);
    wr(`ADDR_PWM_PERIOD, 32'(pwmPer));
    wr(`ADDR_PWM_DUTY, 32'(pwmDuty));
    wr(`ADDR_SQ_PERIOD, 32'(sqPer));
    wr(`ADDR_PWM_SEL, 32'(pwmSel));
    wr(`ADDR_SQ_SEL, 32'(sqSel));
    for (int i = 0; i < 16; i++) begin
      sqDuty[i] = 9'($urandom % 512);
      wr(`ADDR_SQ_DUTY_BASE + 8'(4 * i), 32'(sqDuty[i]));
      if (sqDuty[i] > `SQ_DUTY_FULL) sqDuty[i] = `SQ_DUTY_FULL;
    end
    rdChk("square duty", `ADDR_SQ_DUTY_BASE, 32'(sqDuty[0]));
    wr(`ADDR_CTRL, 32'h0000_0003);
    cmpVal("pinOeN", {16'h0000, ~(pwmSel | sqSel | gpOe)}, 32'(pinOeN));
    repeat (50) @(posedge mclk);
    w = (sqPer == 0) ? 80 * pwmPer : 4 * pwmPer * sqPer;
    measure(w);
    for (int i = 0; i < 16; i++) begin
      cmpVal("pin high count", pinExp(i, w), 32'(highCnt[i]));
    end
    $display("case %0d done", k);
  endtask : runCase

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1500000;
    miscompares++;
    results();
  end

  initial begin
    void'($urandom(13233));
    sysRst = 1'b1;
    {cyc, stb, we, run, clear} = '0;
    sel = 4'h0;
    adr = 8'h00;
    datIn = '0;
    gpOut = 16'h0000;
    gpOe = 16'h0000;
    repeat (20) @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    cmpVal("pinOut after reset", '0, 32'(pinOut));
    rdChk("ctrl", `ADDR_CTRL, '0);
    rdChk("pulse period", `ADDR_PWM_PERIOD, 32'(`PWM_PERIOD_RST));
    rdChk("pulse duty", `ADDR_PWM_DUTY, 32'(`PWM_DUTY_RST));
    rdChk("square period", `ADDR_SQ_PERIOD, 32'(`SQ_PERIOD_RST));
    rdChk("square duty", `ADDR_SQ_DUTY_BASE + 8'h3C, 32'(`SQ_DUTY_RST));
    rdChk("status", `ADDR_STATUS, '0);
    wr(8'h1C, 32'hFFFF_FFFF);
    rdChk("unmapped", 8'h1C, '0);
    wr(`ADDR_PWM_PERIOD, '0);
    rdChk("pulse period floor", `ADDR_PWM_PERIOD, 32'(`PWM_MIN_PERIOD));
    // Byte lane 1 only: low byte keeps the floored value
    wbCycle(1'b1, `ADDR_PWM_PERIOD, 32'h0000_AB00, 4'h2, rdq);
    rdChk("pulse period bytes", `ADDR_PWM_PERIOD, 32'h0000_AB01);
    wr(`ADDR_SQ_PERIOD, 32'h0000_0005);
    rdChk("square period floor", `ADDR_SQ_PERIOD, 32'h0000_000A);
    $display("reset and map test done");
    for (int k = 0; k < 8; k++) runCase(k);
    results();
  end
endmodule : pwm_and_square_wave_outputs_tb
`default_nettype wire
